// >>> logic/post_buck_pkg.sv
// Constants for the post step-down regulator supervisor
// Behaviour
// - The high-side switch turns off within the period as soon as the peak current reaches the limit.
// - Low-side current above the overcurrent threshold at period end blocks the next high-side turn-on.
// - An overcurrent-limited condition lasting the full timeout sets the sticky timeout flag and raises an interrupt.
// - Crossing the warning temperature sets the sticky warning flag and raises an interrupt.
// - Crossing the shutdown temperature disables the converter, emits a shutdown event and sets a sticky flag.
// - A live warning bit follows the present condition while a sticky copy holds it until cleared.
// - In the active state the host sets the output through a pair of voltage codes of 50 mV per step.
// - The output spans 0.9 V to 1.3 V in nine codes at 50 mV spacing.
// - Before start the input pins are compared to a threshold and the result is kept in a readable bit.
package post_buck_pkg;
  // Register byte offsets
  localparam logic [7:0] STATUS_OFS   = 8'h00;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_CLR_OFS  = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS   = 8'h0c;
  localparam logic [7:0] VCODE_OFS    = 8'h10;
  localparam logic [7:0] VCOMP_OFS    = 8'h14;
  localparam logic [7:0] CTRL_OFS     = 8'h18;
  // Sticky bit positions (shared by status, clear and enable)
  localparam int OC_TIMEOUT_BIT  = 0;
  localparam int OT_WARNING_BIT  = 1;
  localparam int OT_SHUTDOWN_BIT = 2;
  localparam int NUM_EVENTS      = 3;
  // Live status bit positions
  localparam int LIVE_WARN_BIT = 0;
  localparam int LIVE_SD_BIT   = 1;
  localparam int LIVE_USE_BIT  = 2;
  localparam int LIVE_RUN_BIT  = 3;
  localparam int LIVE_OCL_BIT  = 4;
  // Control bit positions
  localparam int CTRL_EN_BIT = 0;
  // Voltage code: 0 is 0.9 V, 8 is 1.3 V, 50 mV each
  localparam int          VCODE_W     = 4;
  localparam int          VSTEP_MV    = 50;
  localparam int          VMIN_MV     = 900;
  localparam int          VMAX_MV     = 1300;
  localparam logic [3:0]  VCODE_MAX   = 4'((VMAX_MV - VMIN_MV) / VSTEP_MV);
  localparam logic [3:0]  VCODE_RESET = 4'h7;
  // Overcurrent timeout, typical 100 us, kept within 95..115 us
  localparam int CLK_MHZ        = 100;
  localparam int OC_TIMEOUT_US  = 100;
  localparam int OC_TIMEOUT_CYC = OC_TIMEOUT_US * CLK_MHZ;
  localparam int OC_CNT_W       = 14;
  // Converter states
  typedef enum logic [1:0] {
    ST_DETECT = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_OFF    = 2'b10,
    ST_UNUSED = 2'b11
  } conv_state_t;
  // Inverse code kept in the companion register
  function automatic logic [3:0] vcode_inv(input logic [3:0] c);
    vcode_inv = ~c;
  endfunction : vcode_inv
endpackage : post_buck_pkg

// >>> logic/pin_sync.sv
// Two-stage synchroniser for a vector of pin levels
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i, // System clock
  input  wire logic         rst_i, // Synchronous reset
  input  wire logic [W-1:0] d_i,   // Asynchronous levels
  output logic      [W-1:0] q_o    // Synchronised levels
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  // First stage is read only by the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end
  assign q_o = sync_ff;
endmodule : pin_sync

// >>> logic/oc_timer.sv
// Overcurrent timeout counter
`timescale 1ns/1ns
module oc_timer
  import post_buck_pkg::*;
#(
  parameter int TIMEOUT_CYC = OC_TIMEOUT_CYC
) (
  input  wire logic clk_i,     // System clock
  input  wire logic rst_i,     // Synchronous reset
  input  wire logic limited_i, // Current-limited condition
  output logic      expire_o   // One-cycle pulse at timeout
);
  logic [OC_CNT_W-1:0] cnt_ff;
  logic                done_ff;
  wire  logic          at_end = (cnt_ff == OC_CNT_W'(TIMEOUT_CYC - 1));
  // Count while limited; restart on clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !limited_i) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (!done_ff) begin
      cnt_ff  <= at_end ? cnt_ff : cnt_ff + 1'b1;
      done_ff <= at_end;
    end
  end
  // Fires once per continuous limited stretch
  assign expire_o = limited_i && at_end && !done_ff;
endmodule : oc_timer

// >>> logic/post_buck_supervisor.sv
// Supervisor of the post step-down regulator with Wishbone registers
`timescale 1ns/1ns
module post_buck_supervisor
  import post_buck_pkg::*;
#(
  parameter int TIMEOUT_CYC = OC_TIMEOUT_CYC
) (
  input  wire logic        clk_i,                  // System clock 100 MHz
  input  wire logic        rst_i,                  // Synchronous reset
  input  wire logic        wb_cyc_i,               // Wishbone cycle
  input  wire logic        wb_stb_i,               // Wishbone strobe
  input  wire logic        wb_we_i,                // Wishbone write
  input  wire logic [7:0]  wb_adr_i,               // Byte address
  input  wire logic [3:0]  wb_sel_i,               // Byte enables
  input  wire logic [31:0] wb_dat_i,               // Write data
  output logic      [31:0] wb_dat_o,               // Read data
  output logic             wb_ack_o,               // Acknowledge
  input  wire logic        active_i,               // Device in active state
  input  wire logic        peak_limit_i,           // Peak current at limit
  input  wire logic        ls_overcurrent_i,       // Low-side above threshold
  input  wire logic        period_end_i,           // Switching period end pulse
  input  wire logic        ot_warning_i,           // Warning comparator
  input  wire logic        ot_shutdown_i,          // Shutdown comparator
  input  wire logic        post_buck_input_pins_i, // Use-detect comparator
  output logic             hs_on_o,                // High-side gate
  output logic             conv_enable_o,          // Converter enable
  output logic [3:0]       vout_code_o,            // Applied voltage code
  output logic             thermal_shutdown_event_o, // Shutdown event pulse
  output logic             irq_o                   // Interrupt level
);
  // Pin levels synchronised before use
  logic [4:0] pins_s;
  pin_sync #(.W(5)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({peak_limit_i, ls_overcurrent_i, ot_warning_i, ot_shutdown_i, post_buck_input_pins_i}),
    .q_o   (pins_s)
  );
  wire logic peak_s = pins_s[4];
  wire logic lsoc_s = pins_s[3];
  wire logic warn_s = pins_s[2];
  wire logic sd_s   = pins_s[1];
  wire logic use_s  = pins_s[0];

  conv_state_t          state_ff;
  conv_state_t          nxt_state;
  logic                 use_detected_ff;
  logic [1:0]           det_wait_ff;
  logic                 ctrl_en_ff;
  logic [VCODE_W-1:0]   vcode_ff;
  logic [VCODE_W-1:0]   vcomp_ff;
  logic [NUM_EVENTS-1:0] sticky_ff;
  logic [NUM_EVENTS-1:0] irq_en_ff;
  logic                 skip_ff;
  logic                 hs_ff;
  logic                 warn_d_ff;
  logic                 sd_d_ff;
  logic                 ack_ff;
  logic [31:0]          rdata_ff;

  // Bus decode
  wire logic req      = wb_cyc_i && wb_stb_i && !ack_ff;
  wire logic wr       = req && wb_we_i && wb_sel_i[0];
  wire logic wr_clr   = wr && (wb_adr_i == IRQ_CLR_OFS);
  wire logic wr_en    = wr && (wb_adr_i == IRQ_EN_OFS);
  wire logic wr_vcode = wr && (wb_adr_i == VCODE_OFS);
  wire logic wr_vcomp = wr && (wb_adr_i == VCOMP_OFS);
  wire logic wr_ctrl  = wr && (wb_adr_i == CTRL_OFS);
  wire logic running  = (state_ff == ST_ACTIVE);
  // Code write accepted only active, in range, with matching companion
  wire logic [3:0] wcode   = wb_dat_i[3:0];
  wire logic code_ok       = active_i && (wcode <= VCODE_MAX);
  wire logic pair_ok       = (vcomp_ff == vcode_inv(wcode));

  // Event detection; unused converter reports nothing
  wire logic used        = (state_ff != ST_UNUSED) && (state_ff != ST_DETECT);
  wire logic limited     = running && (lsoc_s || skip_ff);
  wire logic oc_expire;
  wire logic warn_rise   = used && warn_s && !warn_d_ff;
  wire logic sd_rise     = used && sd_s && !sd_d_ff;
  wire logic [NUM_EVENTS-1:0] ev_set;
  assign ev_set[OC_TIMEOUT_BIT]  = oc_expire && used;
  assign ev_set[OT_WARNING_BIT]  = warn_rise;
  assign ev_set[OT_SHUTDOWN_BIT] = sd_rise;

  oc_timer #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_oc (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .limited_i (limited),
    .expire_o  (oc_expire)
  );

  // Converter state: detect, then active, off or unused
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      // Synchroniser clears on reset, so wait until it holds real pin levels
      ST_DETECT: nxt_state = !det_wait_ff[1] ? ST_DETECT :
                             !use_s ? ST_UNUSED : (ctrl_en_ff && !sd_s) ? ST_ACTIVE : ST_DETECT;
      ST_ACTIVE: nxt_state = sd_s ? ST_OFF : (!ctrl_en_ff ? ST_OFF : ST_ACTIVE);
      ST_OFF:    nxt_state = (!sd_s && ctrl_en_ff) ? ST_ACTIVE : ST_OFF;
      ST_UNUSED: nxt_state = ST_UNUSED;
      default:   nxt_state = ST_DETECT;
    endcase
  end

  // State, detection result and edge history
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff        <= ST_DETECT;
      use_detected_ff <= 1'b0;
      det_wait_ff     <= 2'h0;
      warn_d_ff       <= 1'b0;
      sd_d_ff         <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      det_wait_ff <= det_wait_ff[1] ? det_wait_ff : det_wait_ff + 2'h1;
      warn_d_ff <= warn_s;
      sd_d_ff   <= sd_s;
      if (state_ff == ST_DETECT) begin
        use_detected_ff <= use_s;
      end
    end
  end

  // High-side gating per period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hs_ff   <= 1'b0;
      skip_ff <= 1'b0;
    end else if (!running || sd_s) begin
      hs_ff   <= 1'b0;
      skip_ff <= 1'b0;
    end else if (period_end_i) begin
      skip_ff <= lsoc_s;
      hs_ff   <= !lsoc_s;
    end else if (peak_s) begin
      hs_ff <= 1'b0;
    end
  end

  // Sticky flags: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_ff <= '0;
      irq_en_ff <= '0;
    end else begin
      sticky_ff <= (sticky_ff & ~(wr_clr ? wb_dat_i[NUM_EVENTS-1:0] : '0)) | ev_set;
      if (wr_en) begin
        irq_en_ff <= wb_dat_i[NUM_EVENTS-1:0];
      end
    end
  end

  // Control and voltage codes; host keeps steps of one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_en_ff <= 1'b0;
      vcode_ff   <= VCODE_RESET;
      vcomp_ff   <= vcode_inv(VCODE_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_en_ff <= wb_dat_i[CTRL_EN_BIT];
      end
      if (wr_vcomp && active_i) begin
        vcomp_ff <= wcode;
      end
      if (wr_vcode && code_ok && pair_ok) begin
        vcode_ff <= wcode;
      end
    end
  end

  // Read mux
  // Unused converter shows no live faults either
  wire logic [31:0] live_word = {27'h0, limited, running, use_detected_ff, used && sd_s, used && warn_s};
  wire logic [31:0] rd_mux =
    (wb_adr_i == STATUS_OFS)   ? live_word :
    (wb_adr_i == IRQ_STAT_OFS) ? {29'h0, sticky_ff} :
    (wb_adr_i == IRQ_EN_OFS)   ? {29'h0, irq_en_ff} :
    (wb_adr_i == VCODE_OFS)    ? {28'h0, vcode_ff} :
    (wb_adr_i == VCOMP_OFS)    ? {28'h0, vcomp_ff} :
    (wb_adr_i == CTRL_OFS)     ? {31'h0, ctrl_en_ff} : 32'h0;

  // One ack per request, one cycle after it, read data registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      ack_ff   <= req;
      rdata_ff <= (req && !wb_we_i) ? rd_mux : rdata_ff;
    end
  end

  assign wb_ack_o                 = ack_ff;
  assign wb_dat_o                 = rdata_ff;
  assign hs_on_o                  = hs_ff;
  assign conv_enable_o            = running;
  assign vout_code_o              = vcode_ff;
  assign thermal_shutdown_event_o = sd_rise;
  assign irq_o                    = |(sticky_ff & irq_en_ff);

  // Peak current turns the high side off next cycle
  AST_PEAK_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    peak_s && !period_end_i |=> !hs_on_o) else $error("high side on after peak");
  AST_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
    period_end_i && lsoc_s |=> !hs_on_o) else $error("high side on after overcurrent");
  AST_OC_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    ev_set[OC_TIMEOUT_BIT] |=> sticky_ff[OC_TIMEOUT_BIT]) else $error("timeout flag lost");
  AST_NO_AUTO_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    running && !sd_s && ctrl_en_ff |=> running) else $error("converter stopped on its own");
  AST_WARN: assert property (@(posedge clk_i) disable iff (rst_i)
    warn_rise |=> sticky_ff[OT_WARNING_BIT] && live_word[LIVE_WARN_BIT]) else $error("warning not set");
  AST_SD: assert property (@(posedge clk_i) disable iff (rst_i)
    sd_s |=> !conv_enable_o) else $error("converter on during shutdown");
  AST_RANGE: assert property (@(posedge clk_i) disable iff (rst_i)
    vout_code_o <= VCODE_MAX) else $error("voltage code out of range");
  AST_UNUSED: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ST_UNUSED |-> !conv_enable_o && ev_set == '0) else $error("unused converter active");
  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule : post_buck_supervisor

// >>> verification/host_model.sv
// Host model: classic Wishbone master with register tasks
`timescale 1ns/1ns
module host_model
  import post_buck_pkg::*;
#(
  parameter int SETTLE_CYC = 5000
) (
  input  wire logic        clk_i, // System clock
  input  wire logic        ack_i, // Acknowledge
  input  wire logic [31:0] dat_i, // Read data
  output logic             cyc_o, // Cycle
  output logic             stb_o, // Strobe
  output logic             we_o,  // Write
  output logic [7:0]       adr_o, // Address
  output logic [3:0]       sel_o, // Byte enables
  output logic [31:0]      dat_o  // Write data
);
  // Idle bus at time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hf;
    dat_o = 32'h0;
  end
  // One classic cycle; the request stays put until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    dat_o <= ~d; // Released data shows no stale value
  endtask : xfer
  // One code step, companion first, then wait for the output to settle
  task automatic set_code(input logic [3:0] c);
    logic [31:0] q;
    xfer(1'b1, VCOMP_OFS, {28'h0, ~c}, q);
    xfer(1'b1, VCODE_OFS, {28'h0, c}, q);
    repeat (SETTLE_CYC) @(posedge clk_i);
  endtask : set_code
  // Reaction to an overcurrent timeout is the host's own choice
  task automatic conv_off();
    logic [31:0] q;
    xfer(1'b1, CTRL_OFS, 32'h0, q);
  endtask : conv_off
endmodule : host_model

// >>> verification/tb_post_buck_supervisor.sv
// Self-checking bench of the post step-down supervisor
`timescale 1ns/1ns
module tb_post_buck_supervisor
  import post_buck_pkg::*;
;
  localparam int TOC = 20;
  typedef struct {logic we; logic [7:0] adr; logic [31:0] d; logic [31:0] exp;} row_t;
  logic        clk_i, rst_i, cyc, stb, we, ack, active, peak, lsoc, pend, otw, otsd, pins, hs, en, ev, irq;
  logic [7:0]  adr;
  logic [3:0]  sel, vcode;
  logic [31:0] wdat, rdat, q;
  logic [3:0]  ev_cnt = 4'h0;
  int          fails = 0;
  int          total_checks = 0;
  // Ordinary register traffic: write rows, read rows with expected data
  row_t rows [15] = '{
    '{1'b1, CTRL_OFS, 32'h1, 32'h0}, '{1'b0, CTRL_OFS, 32'h0, 32'h1}, '{1'b1, IRQ_EN_OFS, 32'h7, 32'h0},
    '{1'b0, IRQ_EN_OFS, 32'h0, 32'h7}, '{1'b1, VCOMP_OFS, 32'h7, 32'h0}, '{1'b1, VCODE_OFS, 32'h8, 32'h0},
    '{1'b0, VCODE_OFS, 32'h0, 32'h8}, '{1'b1, VCOMP_OFS, 32'h6, 32'h0}, '{1'b1, VCODE_OFS, 32'h9, 32'h0},
    '{1'b0, VCODE_OFS, 32'h0, 32'h8}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b0, STATUS_OFS, 32'h0, 32'h0c},
    '{1'b1, VCOMP_OFS, 32'h8, 32'h0}, '{1'b1, VCODE_OFS, 32'h7, 32'h0}, '{1'b0, VCODE_OFS, 32'h0, 32'h7}};
  post_buck_supervisor #(.TIMEOUT_CYC(TOC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .active_i(active), .peak_limit_i(peak), .ls_overcurrent_i(lsoc), .period_end_i(pend), .ot_warning_i(otw),
    .ot_shutdown_i(otsd), .post_buck_input_pins_i(pins), .hs_on_o(hs), .conv_enable_o(en), .vout_code_o(vcode),
    .thermal_shutdown_event_o(ev), .irq_o(irq));
  host_model #(.SETTLE_CYC(50)) host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // Clock and a count of shutdown event pulses
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (ev === 1'b1) ev_cnt <= ev_cnt + 4'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    host.xfer(1'b0, a, 32'h0, v);
    chk(v, e);
  endtask : rdchk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    host.xfer(1'b1, a, d, v);
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Watchdog far beyond the expected run of about three hundred and thirty cycles
  initial begin
    tick(20000);
    fails++;
    print_verdict();
  end
  // Main sequence
  initial begin
    {rst_i, active, pins} = 3'b111;
    {peak, lsoc, pend, otw, otsd} = 5'b0;
    tick(6);
    rst_i <= 1'b0;
    tick(1);
    chk({ack, hs, en, irq, vcode}, {4'b0, 4'h7});
    for (int i = 0; i < 15; i++) begin
      host.xfer(rows[i].we, rows[i].adr, rows[i].d, q);
      if (!rows[i].we) chk(q, rows[i].exp);
    end
    lsoc <= 1'b1; // Short limited burst must not time out
    tick(10);
    lsoc <= 1'b0;
    tick(4);
    rdchk(IRQ_STAT_OFS, 32'h0);
    pend <= 1'b1;
    tick(1);
    pend <= 1'b0;
    tick(4);
    chk(hs, 1'b1);
    peak <= 1'b1;
    tick(4);
    chk(hs, 1'b0);
    peak <= 1'b0;
    lsoc <= 1'b1;
    tick(4);
    pend <= 1'b1;
    tick(1);
    pend <= 1'b0;
    tick(4);
    chk(hs, 1'b0);
    tick(TOC + 10);
    lsoc <= 1'b0;
    tick(4);
    pend <= 1'b1; // Clean period end ends the skipped state
    tick(1);
    pend <= 1'b0;
    tick(4);
    rdchk(IRQ_STAT_OFS, 32'h1);
    chk({irq, en}, 2'b11);
    wr(IRQ_EN_OFS, 32'h0);
    chk(irq, 1'b0);
    wr(IRQ_EN_OFS, 32'h7);
    wr(IRQ_CLR_OFS, 32'h1);
    rdchk(IRQ_STAT_OFS, 32'h0);
    otw <= 1'b1;
    tick(6);
    rdchk(STATUS_OFS, 32'h0d);
    chk(irq, 1'b1);
    otw <= 1'b0;
    tick(6);
    rdchk(STATUS_OFS, 32'h0c);
    rdchk(IRQ_STAT_OFS, 32'h2);
    wr(IRQ_CLR_OFS, 32'h2);
    otsd <= 1'b1;
    tick(6);
    chk({en, ev_cnt}, 5'h01);
    otsd <= 1'b0;
    tick(6);
    chk(en, 1'b1);
    rdchk(IRQ_STAT_OFS, 32'h4);
    host.conv_off();
    tick(1);
    chk(en, 1'b0);
    active <= 1'b0;
    host.set_code(4'h6);
    chk(vcode, 4'h7);
    active <= 1'b1;
    host.set_code(4'h6);
    chk(vcode, 4'h6);
    {rst_i, pins} <= 2'b10; // Second reset with the converter unused
    tick(6);
    rst_i <= 1'b0;
    tick(8);
    wr(CTRL_OFS, 32'h1);
    otw <= 1'b1;
    tick(8);
    chk({en, irq}, 2'b00);
    rdchk(STATUS_OFS, 32'h0);
    rdchk(IRQ_STAT_OFS, 32'h0);
    print_verdict();
  end
endmodule : tb_post_buck_supervisor
